// >>> pkg/smc_pkg.sv
// Constants, register map and state codes of the sleep-mode controller.
// Assumes a single 200 MHz clock and an AXI4-Lite master on the register side.
package smc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_COMP   = 12'h004;
  localparam logic [11:0] ADDR_INDIS  = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;

  localparam int MODE_HI_BIT  = 6;
  localparam int ENABLE_BIT   = 5;
  localparam int MODE_LO_BIT  = 4;
  localparam int COMP_DIS_BIT = 7;
  localparam int COMP_REF_BIT = 6;

  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] COMP_RESET  = 8'h00;
  localparam logic [7:0] INDIS_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Mode codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_IDLE  = 2'b00;
  localparam logic [1:0] MODE_PDOWN = 2'b01;
  localparam logic [1:0] MODE_STBY  = 2'b10;

  localparam logic [2:0] BOD_OFF_FUSES = 3'b111;

  localparam logic [8:0] STBY_WAKE_CYC = 9'h006;
  localparam logic [8:0] HALT_CYC      = 9'h004;
  localparam logic [8:0] PD_WAKE_CYC0  = 9'h006;
  localparam logic [8:0] PD_WAKE_CYC1  = 9'h010;
  localparam logic [8:0] PD_WAKE_CYC2  = 9'h040;
  localparam logic [8:0] PD_WAKE_CYC3  = 9'h100;

  typedef enum logic [5:0] {
    ST_ACTIVE  = 6'b000001,
    ST_IDLE    = 6'b000010,
    ST_PDOWN   = 6'b000100,
    ST_STBY    = 6'b001000,
    ST_STARTUP = 6'b010000,
    ST_HALT    = 6'b100000
  } smc_state_t;

endpackage

// >>> rtl/smc_sleep_ctrl.sv
// Sleep-mode controller: mode register, clock gating, wake-up and power gating.
// Assumes the core pulses sleepInstr for one cycle and stalls while coreHalt is high.
`timescale 1ns/1ps

module smc_sleep_ctrl #(
  parameter int NPINS = 8
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    sleepInstr,
  input  wire logic                    irqPending,
  input  wire logic                    compIrq,
  input  wire logic                    extIntZeroLevel,
  input  wire logic                    pinChangeIrq,
  input  wire logic                    usiStartIrq,
  input  wire logic                    extResetReq,
  input  wire logic                    wdtResetReq,
  input  wire logic                    bodResetReq,
  input  wire logic                    crystalSelected,
  input  wire logic [1:0]              clockSourceFuses,
  input  wire logic [2:0]              brownoutLevelFuses,
  input  wire logic                    wdtEnable,
  input  wire logic [NPINS-1:0]        wakePinMask,
  output logic                         cpuClkEn,
  output logic                         flashClkEn,
  output logic                         ioClkEn,
  output logic                         oscEn,
  output logic                         compPowerEn,
  output logic                         vrefEn,
  output logic                         bodEn,
  output logic                         wdtRunEn,
  output logic [NPINS-1:0]             inputBufEn,
  output logic                         coreHalt,
  output logic                         irqServe,
  output logic                         resetVector,
  output logic                         sleepNop,
  output smc_pkg::smc_state_t          sleepState
);
  import smc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] syncA_q;
  logic [NSYNC-1:0] syncB_q;
  logic             lvlZero;
  logic             pinChg;
  logic             usiStart;
  logic             anyReset;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= {bodResetReq, wdtResetReq, extResetReq,
                  usiStartIrq, pinChangeIrq, extIntZeroLevel};
      syncB_q <= syncA_q;
    end
  end

  assign lvlZero  = syncB_q[0];
  assign pinChg   = syncB_q[1];
  assign usiStart = syncB_q[2];
  assign anyReset = |syncB_q[5:3];

  // ----------------------------------------------------------------
  // Registers and AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  comp_q;
  logic [7:0]  inDis_q;
  logic        awHave_q;
  logic        wHave_q;
  logic [11:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        bValid_q;
  logic [1:0]  bResp_q;
  logic        rValid_q;
  logic [31:0] rData_q;
  logic [1:0]  rResp_q;
  logic        doWrite;
  logic        wrHit;

  assign s_axi_awready = !awHave_q;
  assign s_axi_wready  = !wHave_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;
  assign doWrite       = awHave_q && wHave_q && !bValid_q;
  assign wrHit         = (awAddr_q == ADDR_CTRL) || (awAddr_q == ADDR_COMP)
                         || (awAddr_q == ADDR_INDIS);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHave_q) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_q) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries register bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q  <= CTRL_RESET;
      comp_q  <= COMP_RESET;
      inDis_q <= INDIS_RESET;
    end else if (doWrite && wStrb_q[0]) begin
      if (awAddr_q == ADDR_CTRL) begin
        ctrl_q <= wData_q[7:0];
      end else if (awAddr_q == ADDR_COMP) begin
        comp_q <= wData_q[7:0];
      end else if (awAddr_q == ADDR_INDIS) begin
        inDis_q <= wData_q[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sleep state machine
  // ----------------------------------------------------------------
  smc_state_t state_q;
  logic [8:0] cnt_q;
  logic [1:0] modeSel;
  logic       sleepEnable;
  logic       compDisabled;
  logic       idleWake;
  logic       pdWake;
  logic [8:0] pdDelay;

  assign modeSel      = {ctrl_q[MODE_HI_BIT], ctrl_q[MODE_LO_BIT]};
  assign sleepEnable  = ctrl_q[ENABLE_BIT];
  assign compDisabled = comp_q[COMP_DIS_BIT];
  assign idleWake     = irqPending || (compIrq && !compDisabled);
  assign pdWake       = lvlZero || pinChg || usiStart;

  always_comb begin
    if (clockSourceFuses == 2'b00) begin
      pdDelay = PD_WAKE_CYC0;
    end else if (clockSourceFuses == 2'b01) begin
      pdDelay = PD_WAKE_CYC1;
    end else if (clockSourceFuses == 2'b10) begin
      pdDelay = PD_WAKE_CYC2;
    end else begin
      pdDelay = PD_WAKE_CYC3;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= ST_ACTIVE;
      cnt_q       <= 9'h000;
      irqServe    <= 1'b0;
      resetVector <= 1'b0;
      sleepNop    <= 1'b0;
    end else begin
      irqServe    <= 1'b0;
      resetVector <= 1'b0;
      sleepNop    <= 1'b0;
      if (anyReset && (state_q != ST_ACTIVE)) begin
        state_q     <= ST_ACTIVE;
        resetVector <= 1'b1;
      end else begin
        case (state_q)
          ST_ACTIVE: begin
            if (sleepInstr && !sleepEnable) begin
              sleepNop <= 1'b1;
            end else if (sleepInstr) begin
              if (modeSel == MODE_IDLE) begin
                state_q <= ST_IDLE;
              end else if (modeSel == MODE_STBY && crystalSelected) begin
                state_q <= ST_STBY;
              end else begin
                state_q <= ST_PDOWN;
              end
            end
          end
          ST_IDLE: begin
            if (idleWake) begin
              state_q <= ST_HALT;
              cnt_q   <= HALT_CYC - 9'h001;
            end
          end
          ST_PDOWN: begin
            if (pdWake) begin
              state_q <= ST_STARTUP;
              cnt_q   <= pdDelay - 9'h001;
            end
          end
          ST_STBY: begin
            if (pdWake) begin
              state_q <= ST_STARTUP;
              cnt_q   <= STBY_WAKE_CYC - 9'h001;
            end
          end
          ST_STARTUP: begin
            if (cnt_q == 9'h000) begin
              state_q <= ST_HALT;
              cnt_q   <= HALT_CYC - 9'h001;
            end else begin
              cnt_q <= cnt_q - 9'h001;
            end
          end
          ST_HALT: begin
            if (cnt_q == 9'h000) begin
              state_q  <= ST_ACTIVE;
              irqServe <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 9'h001;
            end
          end
          default: begin
            state_q <= ST_ACTIVE;
          end
        endcase
      end
    end
  end

  assign sleepState = state_q;
  assign coreHalt   = (state_q != ST_ACTIVE);

  // ----------------------------------------------------------------
  // Clock and power gating
  // ----------------------------------------------------------------
  logic deepSleep;
  logic bodOn;
  logic refForComp;
  assign deepSleep  = (state_q == ST_PDOWN) || (state_q == ST_STBY)
                      || (state_q == ST_STARTUP);
  assign bodOn      = (brownoutLevelFuses != BOD_OFF_FUSES);
  // Reference held for a comparator that selects it (COMP_REF_BIT) and is not disabled by software, in any mode
  assign refForComp = comp_q[COMP_REF_BIT] && !compDisabled;

  // CPU, flash and I/O clock enables and input buffers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpuClkEn   <= 1'b1;
      flashClkEn <= 1'b1;
      ioClkEn    <= 1'b1;
      oscEn      <= 1'b1;
      inputBufEn <= '1;
    end else begin
      cpuClkEn   <= (state_q == ST_ACTIVE);
      flashClkEn <= (state_q == ST_ACTIVE);
      ioClkEn    <= !deepSleep;
      oscEn      <= (state_q != ST_PDOWN);
      inputBufEn <= ~inDis_q[NPINS-1:0]
                    & (deepSleep ? wakePinMask : {NPINS{1'b1}});
    end
  end

  // Analog blocks, reference and monitors; comparator power drops in power-down, standby and start-up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compPowerEn <= 1'b1;
      vrefEn      <= 1'b0;
      bodEn       <= 1'b0;
      wdtRunEn    <= 1'b0;
    end else begin
      compPowerEn <= !compDisabled && !deepSleep;
      vrefEn      <= bodOn || refForComp;
      bodEn       <= bodOn;
      wdtRunEn    <= wdtEnable;
    end
  end

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h00000000;
      rResp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rValid_q) begin
      rValid_q <= 1'b1;
      rResp_q  <= RESP_OKAY;
      if (s_axi_araddr == ADDR_CTRL) begin
        rData_q <= {24'h000000, ctrl_q};
      end else if (s_axi_araddr == ADDR_COMP) begin
        rData_q <= {24'h000000, comp_q};
      end else if (s_axi_araddr == ADDR_INDIS) begin
        rData_q <= {24'h000000, inDis_q};
      end else if (s_axi_araddr == ADDR_STATUS) begin
        rData_q <= {18'h00000, vrefEn, compPowerEn, oscEn, ioClkEn,
                    flashClkEn, cpuClkEn, 2'b00, state_q};
      end else begin
        rData_q <= 32'h00000000;
        rResp_q <= RESP_SLVERR;
      end
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

endmodule

// >>> testbench/smc_core_model.sv
// Core stand-in: issues the sleep instruction and raises interrupts.
// Assumes the bench calls its tasks from the clk domain.
`timescale 1ns/1ps

module smc_core_model (
  input  wire logic clk,
  output logic      sleepInstr,
  output logic      irqPending
);
  initial begin
    sleepInstr = 1'b0;
    irqPending = 1'b0;
  end

  task automatic do_sleep();
    @(posedge clk);
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
  endtask

  task automatic set_irq(input logic v);
    @(posedge clk);
    irqPending <= v;
  endtask
endmodule

// >>> testbench/smc_sleep_ctrl_chk.sv
// Port checks on the sleep controller.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps

module smc_sleep_ctrl_chk #(
  parameter int NPINS = 8
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                sleepInstr,
  input wire logic                irqPending,
  input wire logic [2:0]          brownoutLevelFuses,
  input wire logic                wdtEnable,
  input wire logic [NPINS-1:0]    wakePinMask,
  input wire logic                cpuClkEn,
  input wire logic                flashClkEn,
  input wire logic                ioClkEn,
  input wire logic                oscEn,
  input wire logic                compPowerEn,
  input wire logic                bodEn,
  input wire logic                wdtRunEn,
  input wire logic [NPINS-1:0]    inputBufEn,
  input wire logic                irqServe,
  input wire logic                sleepNop,
  input wire smc_pkg::smc_state_t sleepState
);
  import smc_pkg::*;
  // --------------------------------
  // Entry, gating and wake timing
  // --------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  nop_entry_a: assert property (
    sleepInstr && sleepState == ST_ACTIVE |=> sleepNop == (sleepState == ST_ACTIVE))
    else $error("sleep entry and no-op pulse disagree");
  idle_gate_a: assert property (
    (sleepState == ST_IDLE)[*2] |-> !cpuClkEn && !flashClkEn && ioClkEn && oscEn)
    else $error("idle clock gating wrong");
  pdown_gate_a: assert property (
    (sleepState == ST_PDOWN)[*2] |-> !oscEn && !ioClkEn && !compPowerEn
      && (inputBufEn & ~wakePinMask) == '0)
    else $error("power-down gating wrong");
  stby_gate_a: assert property (
    (sleepState == ST_STBY)[*2] |-> oscEn && !ioClkEn && !cpuClkEn && !compPowerEn)
    else $error("standby gating wrong");
  idle_wake_a: assert property (
    sleepState == ST_IDLE && irqPending |=> sleepState == ST_HALT)
    else $error("idle did not wake on interrupt");
  halt_len_a: assert property (
    $rose(sleepState == ST_HALT) |-> (sleepState == ST_HALT)[*4]
      ##1 (sleepState == ST_ACTIVE && irqServe))
    else $error("halt length or serve pulse wrong");
  stby_wake_a: assert property (
    sleepState == ST_STARTUP && $past(sleepState) == ST_STBY
      |-> (sleepState == ST_STARTUP)[*6] ##1 sleepState == ST_HALT)
    else $error("standby wake delay wrong");
  bod_keep_a: assert property (
    $past(rst_n) |-> bodEn == ($past(brownoutLevelFuses) != BOD_OFF_FUSES))
    else $error("brown-out enable does not follow fuses");
  wdt_keep_a: assert property (
    $past(rst_n) |-> wdtRunEn == $past(wdtEnable))
    else $error("watchdog run enable does not follow enable");
endmodule

bind smc_sleep_ctrl smc_sleep_ctrl_chk #(.NPINS(NPINS)) smc_sleep_ctrl_chk_inst (
  .clk(clk), .rst_n(rst_n), .sleepInstr(sleepInstr), .irqPending(irqPending),
  .brownoutLevelFuses(brownoutLevelFuses), .wdtEnable(wdtEnable),
  .wakePinMask(wakePinMask), .cpuClkEn(cpuClkEn), .flashClkEn(flashClkEn),
  .ioClkEn(ioClkEn), .oscEn(oscEn), .compPowerEn(compPowerEn), .bodEn(bodEn),
  .wdtRunEn(wdtRunEn), .inputBufEn(inputBufEn), .irqServe(irqServe),
  .sleepNop(sleepNop), .sleepState(sleepState));

// >>> testbench/smc_sleep_ctrl_test.sv
// Self-checking bench for the sleep controller over AXI4-Lite.
// Assumes the core model beside the design and the bound checker.
`timescale 1ns/1ps

module smc_sleep_ctrl_test;
  import smc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic sleepInstr, irqPending, compIrq = 0, crystal = 1, wdtOn = 0;
  logic [2:0] wakeLvl = '0, rstReq = '0, bodFuse = 3'b111;
  logic [1:0] ckFuse = '0;
  logic [7:0] mask = 8'hA5, inputBufEn;
  logic cpuClkEn, flashClkEn, ioClkEn, oscEn, compPowerEn, vrefEn, bodEn, wdtRunEn;
  logic coreHalt, irqServe, resetVector, sleepNop;
  smc_state_t sleepState;
  smc_state_t modeSt[4] = '{ST_IDLE, ST_PDOWN, ST_STBY, ST_PDOWN};
  int startExp[4] = '{0, 16, 6, 256};
  int bad_count = 0, num_checks = 0;

  always #2.5 clk = ~clk;

  smc_sleep_ctrl smc_sleep_ctrl_inst (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleepInstr(sleepInstr), .irqPending(irqPending), .compIrq(compIrq),
    .extIntZeroLevel(wakeLvl[0]), .pinChangeIrq(wakeLvl[1]), .usiStartIrq(wakeLvl[2]),
    .extResetReq(rstReq[0]), .wdtResetReq(rstReq[1]), .bodResetReq(rstReq[2]),
    .crystalSelected(crystal), .clockSourceFuses(ckFuse), .brownoutLevelFuses(bodFuse),
    .wdtEnable(wdtOn), .wakePinMask(mask), .cpuClkEn(cpuClkEn), .flashClkEn(flashClkEn),
    .ioClkEn(ioClkEn), .oscEn(oscEn), .compPowerEn(compPowerEn), .vrefEn(vrefEn),
    .bodEn(bodEn), .wdtRunEn(wdtRunEn), .inputBufEn(inputBufEn), .coreHalt(coreHalt),
    .irqServe(irqServe), .resetVector(resetVector), .sleepNop(sleepNop),
    .sleepState(sleepState));

  smc_core_model smc_core_model_inst (.clk(clk), .sleepInstr(sleepInstr),
    .irqPending(irqPending));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 600) begin
      chk("wait", 0, n);
      wrap_up();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw = 0, w = 0;
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(negedge clk);
      aw = aw | awready;
      w = w | wready;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
      tmo(n);
    end
    bready <= 1'b1;
    do begin @(negedge clk); n++; tmo(n); end while (!bvalid);
    chk("bresp", er, bresp);
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(negedge clk); n++; tmo(n); end while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do begin @(negedge clk); n++; tmo(n); end while (!rvalid);
    chk("rdata", e, rdata);
    chk("rresp", er, rresp);
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // Counts start-up cycles until the serve or reset-vector pulse
  task automatic wake_wait(input int es, input bit rv, input string n);
    int c = 0, k = 0;
    do begin
      @(negedge clk);
      if (sleepState == ST_STARTUP) c++;
      k++;
      tmo(k);
    end while ((rv ? resetVector : irqServe) !== 1'b1);
    chk(n, es, c);
    chk("state", ST_ACTIVE, sleepState);
  endtask

  task automatic enter(input logic [31:0] ctl);
    wr(ADDR_CTRL, ctl, RESP_OKAY);
    smc_core_model_inst.do_sleep();
    repeat (2) @(negedge clk);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, 0, RESP_OKAY);
    rd(ADDR_COMP, 0, RESP_OKAY);
    rd(ADDR_INDIS, 0, RESP_OKAY);
    rd(12'h010, 0, RESP_SLVERR);
    wr(12'h010, 32'hFF, RESP_SLVERR);
    wr(ADDR_INDIS, 32'h01, RESP_OKAY);
    rd(ADDR_INDIS, 32'h01, RESP_OKAY);
    chk("inbuf", 8'hFE, inputBufEn);
    wr(ADDR_INDIS, 0, RESP_OKAY);
    $display("test registers done");
    wr(ADDR_CTRL, 32'h10, RESP_OKAY);
    smc_core_model_inst.do_sleep();
    @(negedge clk);
    chk("nop", 1, sleepNop);
    chk("state", ST_ACTIVE, sleepState);
    $display("test disabled sleep done");
    for (int m = 0; m < 4; m++) begin
      ckFuse <= 2'(m);
      enter({25'h0, m[1], 1'b1, m[0], 4'h0});
      chk("mode", modeSt[m], sleepState);
      chk("cpu", 0, cpuClkEn);
      chk("io", m == 0, ioClkEn);
      chk("osc", m == 0 || m == 2, oscEn);
      chk("comp", m == 0, compPowerEn);
      chk("inbuf", m == 0 ? 8'hFF : mask, inputBufEn);
      if (m == 0) smc_core_model_inst.set_irq(1'b1);
      else begin
        @(posedge clk);
        wakeLvl[m-1] <= 1'b1;
      end
      wake_wait(startExp[m], 0, "startup");
      smc_core_model_inst.set_irq(1'b0);
      wakeLvl <= '0;
      wr(ADDR_CTRL, 0, RESP_OKAY);
    end
    $display("test sleep modes done");
    crystal <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      enter(32'h60);
      chk("nocrystal", ST_PDOWN, sleepState);
      @(posedge clk);
      rstReq[i] <= 1'b1;
      wake_wait(0, 1, "rstwake");
      @(posedge clk);
      rstReq <= '0;
    end
    $display("test reset wake done");
    bodFuse <= 3'b110;
    wdtOn <= 1'b1;
    wr(ADDR_COMP, 32'h40, RESP_OKAY);
    @(negedge clk);
    chk("bod", 1, bodEn);
    chk("wdt", 1, wdtRunEn);
    chk("vref", 1, vrefEn);
    enter(32'h20);
    chk("vref", 1, vrefEn);
    chk("comp", 1, compPowerEn);
    @(posedge clk);
    compIrq <= 1'b1;
    wake_wait(0, 0, "compwake");
    @(posedge clk);
    compIrq <= 1'b0;
    bodFuse <= 3'b111;
    ckFuse <= 2'b00;
    enter(32'h30);
    chk("pdvref", 1, vrefEn);
    @(posedge clk);
    wakeLvl[0] <= 1'b1;
    wake_wait(6, 0, "pdfast");
    chk("keptvref", 1, vrefEn);
    @(posedge clk);
    wakeLvl <= '0;
    wr(ADDR_CTRL, 0, RESP_OKAY);
    wr(ADDR_COMP, 32'hC0, RESP_OKAY);
    @(negedge clk);
    chk("vref", 0, vrefEn);
    chk("comp", 0, compPowerEn);
    enter(32'h20);
    @(posedge clk);
    compIrq <= 1'b1;
    repeat (8) @(negedge clk);
    chk("compoff", ST_IDLE, sleepState);
    smc_core_model_inst.set_irq(1'b1);
    compIrq <= 1'b0;
    wake_wait(0, 0, "irqwake");
    smc_core_model_inst.set_irq(1'b0);
    wr(ADDR_CTRL, 0, RESP_OKAY);
    $display("test comparator done");
    wrap_up();
  end
endmodule
